// ==== pwd_pwm8.sv ====
// eight-channel 8-bit pwm dac generator with ahb-lite registers
`timescale 1ns/1ps
module pwd_pwm8
   import pwd_pkg::*;
(
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // pins 8..15
   output logic      [NUM_CH-1:0] pwm_out_pin
);
   pwd_state_s s_q, s_d;
   logic [3:0] idx;
   logic [3:0] step;
   logic       wact;
   logic       racc;
   logic [2:0] ci;

   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign hrdata      = s_q.rdata;
   assign pwm_out_pin = s_q.pin;
   assign idx         = s_q.cnt[7:4];
   assign step        = s_q.cnt[3:0];
   assign wact        = s_q.bus.act & s_q.bus.wr;
   assign racc        = hsel & hready & htrans[1] & ~hwrite;
   assign ci          = haddr[4:2];

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      // address phase capture
      s_d.bus.act  = hsel & hready & htrans[1];
      s_d.bus.wr   = hwrite;
      s_d.bus.addr = haddr[7:0];
      // data phase writes
      if (wact) begin
         if (s_q.bus.addr < OFS_POL) begin
            s_d.duty[s_q.bus.addr[4:2]] = hwdata[7:0];
         end
         case (s_q.bus.addr)
            OFS_POL:  s_d.pol  = hwdata[7:0];
            OFS_OSEL: s_d.osel = hwdata[7:0];
            OFS_PORT: s_d.port = hwdata[7:0];
            OFS_CLK:  s_d.clk  = hwdata[3:0];
            default: ;
         endcase
      end
      // read data registered at address phase
      if (racc) begin
         if (haddr[7:0] < OFS_POL) begin
            s_d.rdata = {24'h0, s_q.duty[ci]};
         end else begin
            case (haddr[7:0])
               OFS_POL:  s_d.rdata = {24'h0, s_q.pol};
               OFS_OSEL: s_d.rdata = {24'h0, s_q.osel};
               OFS_PORT: s_d.rdata = {24'h0, s_q.port};
               OFS_CLK:  s_d.rdata = {28'h0, s_q.clk};
               OFS_STAT: s_d.rdata = {16'h0, s_q.cnt, s_q.pin};
               default:  s_d.rdata = 32'h0;
            endcase
         end
      end
      // prescaler: one tick per selected timer period
      if (s_q.clk[CLK_EN_BIT]) begin
         s_d.pre = s_q.pre + 5'h01;
         case (s_q.clk[2:0])
            3'h0:    s_d.tick = 1'b1;
            3'h1:    s_d.tick = s_q.pre[0];
            3'h2:    s_d.tick = &s_q.pre[1:0];
            3'h3:    s_d.tick = &s_q.pre[2:0];
            DIV_16:  s_d.tick = &s_q.pre[3:0];
            default: s_d.tick = 1'b1;
         endcase
      end else begin
         s_d.pre = 5'h00;
      end
      if (s_q.tick) begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
      // per-channel waveform
      for (int i = 0; i < NUM_CH; i++) begin
         logic [4:0] hi;
         logic       w;
         hi = {1'b0, s_q.duty[i][7:4]}
              + {4'h0, extra_pulse(s_q.duty[i][3:0], idx)};
         w  = {1'b0, step} < hi;
         w  = w ^ s_q.pol[i];
         s_d.pin[i] = s_q.osel[i] ? w : s_q.port[i];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q       <= '0;
         s_q.duty  <= {NUM_CH{RST_DUTY}};
         s_q.clk   <= RST_CLK;
      end else begin
         s_q <= s_d;
      end
   end

   // assertions
   property p_wrap;
      @(posedge hclk) disable iff (!hresetn)
         (s_q.tick && s_q.cnt == 8'hff) |=> s_q.cnt == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("period did not wrap");
   property p_period;
      @(posedge hclk) disable iff (!hresetn) s_q.tick |=> s_q.cnt == $past(s_q.cnt) + 8'h01;
   endproperty
   a_period: assert property (p_period) else $error("counter did not step");
   property p_zero;
      @(posedge hclk) disable iff (!hresetn)
         (s_q.osel[0] && s_q.duty[0] == 8'h00 && !s_q.pol[0]) |=> !pwm_out_pin[0];
   endproperty
   a_zero: assert property (p_zero) else $error("zero duty not low");
   property p_port;
      @(posedge hclk) disable iff (!hresetn)
         (!s_q.osel[1]) |=> pwm_out_pin[1] == $past(s_q.port[1]);
   endproperty
   a_port: assert property (p_port) else $error("port data not on pin");
   property p_full;
      @(posedge hclk) disable iff (!hresetn)
         (s_q.osel[2] && s_q.duty[2] == 8'hff && !s_q.pol[2] && step == 4'hf
          && idx == 4'hf) |=> !pwm_out_pin[2];
   endproperty
   a_full: assert property (p_full) else $error("ff duty reached full high");
   property p_pol;
      @(posedge hclk) disable iff (!hresetn)
         (s_q.osel[3] && s_q.pol[3] && s_q.duty[3] == 8'h00) |=> pwm_out_pin[3];
   endproperty
   a_pol: assert property (p_pol) else $error("inversion missing");
   property p_div1;
      @(posedge hclk) disable iff (!hresetn)
         (s_q.clk == 4'h8) |=> s_q.tick;
   endproperty
   a_div1: assert property (p_div1) else $error("undivided clock not ticking");
   property p_off;
      @(posedge hclk) disable iff (!hresetn)
         (!s_q.clk[CLK_EN_BIT] && $past(!s_q.clk[CLK_EN_BIT])) |-> !s_q.tick;
   endproperty
   a_off: assert property (p_off) else $error("tick while disabled");
   property p_extra;
      @(posedge hclk) disable iff (!hresetn)
         (s_q.osel[4] && !s_q.pol[4] && s_q.duty[4] == 8'h01 && idx == 4'h0
          && step == 4'h0) |=> pwm_out_pin[4];
   endproperty
   a_extra: assert property (p_extra) else $error("extra step missing");
   c_wrap: cover property (@(posedge hclk) s_q.tick && s_q.cnt == 8'hff);
   c_pin:  cover property (@(posedge hclk) $rose(pwm_out_pin[0]));
   c_wr:   cover property (@(posedge hclk) wact && s_q.bus.addr == OFS_CLK);
endmodule : pwd_pwm8

// ==== pwd_pkg.sv ====
// package for the eight-channel 8-bit pwm dac block
package pwd_pkg;
   localparam int unsigned NUM_CH       = 8;
   localparam int unsigned FIRST_CH     = 8;
   // register byte offsets
   localparam logic [7:0]  OFS_DUTY0    = 8'h00;  // duty of channel 8 .. 15 at 00..1c
   localparam logic [7:0]  OFS_POL      = 8'h20;
   localparam logic [7:0]  OFS_OSEL     = 8'h24;
   localparam logic [7:0]  OFS_PORT     = 8'h28;
   localparam logic [7:0]  OFS_CLK      = 8'h2c;
   localparam logic [7:0]  OFS_STAT     = 8'h30;
   // clock control fields
   localparam int unsigned CLK_EN_BIT   = 3;
   localparam logic [2:0]  DIV_1        = 3'h0;
   localparam logic [2:0]  DIV_16       = 3'h4;
   // reset values
   localparam logic [7:0]  RST_DUTY     = 8'h00;
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [3:0]  RST_CLK      = 4'h0;
   // timing
   localparam real         RES_NS       = 100.0;
   localparam real         CLK_NS       = 5.0;
   localparam int unsigned RES_CYC      = (RES_NS / CLK_NS) < 1.0 ? 1 : int'($floor(RES_NS / CLK_NS));
   localparam int unsigned PER_STEPS    = 256;
   localparam int unsigned BASIC_PULSES = 16;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       act;
   } pwd_bus_s;

   typedef struct packed {
      logic [NUM_CH-1:0][7:0] duty;
      logic [7:0]             pol;
      logic [7:0]             osel;
      logic [7:0]             port;
      logic [3:0]             clk;
      logic [4:0]             pre;
      logic [7:0]             cnt;
      logic                   tick;
      logic [NUM_CH-1:0]      pin;
      pwd_bus_s               bus;
      logic [31:0]            rdata;
   } pwd_state_s;

   // bit-reversed position of a basic pulse spreads additional pulses evenly
   function automatic logic extra_pulse(input logic [3:0] n, input logic [3:0] idx);
      return {idx[0], idx[1], idx[2], idx[3]} < n;
   endfunction : extra_pulse
endpackage : pwd_pkg

// ==== pwd_rc_model.sv ====
// partner model: rc filter treated as an integrator of pin high time
`timescale 1ns/1ps
module pwd_rc_model (
   // clock and window control
   input  wire logic        hclk,
   input  wire logic        clr,
   // pin in, averaged level out
   input  wire logic        pin,
   output logic      [31:0] level
);
   always @(posedge hclk) begin
      level <= clr ? 32'h0 : level + {31'h0, pin === 1'h1};
   end
endmodule : pwd_rc_model

// ==== pwd_pwm8_tb.sv ====
// testbench for the pwm dac generator
`timescale 1ns/1ps
module pwd_pwm8_tb
   import pwd_pkg::*;
;
   logic              hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic              clr = 1'h1, hreadyout, hresp;
   logic [1:0]        htrans = 2'h0;
   logic [2:0]        hsize = 3'h2;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, rd, level;
   logic [NUM_CH-1:0] pwm_out_pin;
   logic [7:0]        dv [5] = '{8'h00, 8'h10, 8'hf0, 8'hff, 8'h35};
   int                errors = 0, checks_done = 0;

   always #2.5 hclk = ~hclk;

   pwd_pwm8 pwd_pwm8_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_out_pin(pwm_out_pin));
   pwd_rc_model pwd_rc_model_i (.hclk(hclk), .clr(clr), .pin(pwm_out_pin[0]), .level(level));

   task test_done;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // one ahb-lite single word transfer, read data left in rd
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      rd = hrdata;
   endtask : xfer

   // settle, then count pin high cycles over one conversion period
   task meas(input string n, input int cyc, input logic [31:0] e);
      repeat (2 * cyc) @(posedge hclk);
      clr <= 1'h0;
      repeat (cyc) @(posedge hclk);
      @(negedge hclk);
      chk(n, e, level);
      @(posedge hclk);
      clr <= 1'h1;
   endtask : meas

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      xfer(OFS_STAT, 1'h0, 32'h0);
      chk("stat", 32'h0, {16'h0, 8'h0, rd[7:0]});
      chk("hresp", 32'h0, {31'h0, hresp});
      xfer(OFS_CLK, 1'h1, 32'h8);
      xfer(OFS_OSEL, 1'h1, 32'h1);
      foreach (dv[i]) begin
         xfer(OFS_DUTY0, 1'h1, {24'h0, dv[i]});
         meas("duty", 256, {24'h0, dv[i]});
      end
      xfer(OFS_DUTY0, 1'h0, 32'h0);
      chk("duty_rb", 32'h35, rd);
      xfer(8'h40, 1'h0, 32'h0);
      chk("unmapped", 32'h0, rd);
      xfer(OFS_POL, 1'h1, 32'h1);
      meas("invert", 256, 32'hcb);
      xfer(OFS_POL, 1'h1, 32'h0);
      xfer(OFS_CLK, 1'h1, {28'h0, 1'h1, DIV_16});
      meas("div16", 4096, 32'h350);
      xfer(OFS_PORT, 1'h1, 32'h1);
      xfer(OFS_OSEL, 1'h1, 32'h0);
      meas("port", 256, 32'h100);
      test_done();
   end

   initial begin
      repeat (40000) @(posedge hclk);
      errors++;
      test_done();
   end
endmodule : pwd_pwm8_tb
